// ### hw/pps_params.svh
`ifndef PPS_PARAMS_SVH
`define PPS_PARAMS_SVH
`define PPS_CLK_HZ 40000000
`define PPS_STAMP_MS 1
`define PPS_MS_CYCLES (`PPS_CLK_HZ / 1000 * `PPS_STAMP_MS)
`define PPS_PROC_MS 5
`define PPS_PRE_SHORT_MS 20
`define PPS_PRE_LONG_MS 200
`define PPS_SHORT_TICKS (`PPS_PRE_SHORT_MS / `PPS_PROC_MS)
`define PPS_LONG_TICKS (`PPS_PRE_LONG_MS / `PPS_PROC_MS)
`define PPS_OVER_RESET_PCT 97
`define PPS_UNDER_RESET_PCT 103
`define PPS_PCT_SCALE 64'sd20000
`define PPS_RATIO_SCALE 64'sd100
`define PPS_STAGES 4
`define PPS_GROUPS 8
`define PPS_LOG_DEPTH 12
`define PPS_LOG_WORDS 6
`define PPS_OFF_CTRL 2'h0
`define PPS_OFF_NOM_MAN 2'h1
`define PPS_OFF_TIME 2'h2
`define PPS_OFF_NOM_USED 2'h3
`define PPS_PAGE_STAGE 4'h1
`define PPS_PAGE_GROUP 4'h2
`define PPS_CTRL_SG_LSB 0
`define PPS_CTRL_FORCE 3
`define PPS_CTRL_NSRC_LSB 4
`define PPS_CFG_MAG_LSB 0
`define PPS_CFG_UNDER 2
`define PPS_CFG_LN_LSB 3
`define PPS_CFG_EVON 6
`define PPS_CFG_EVOFF 7
`define PPS_CFG_FSW 8
`define PPS_CTRL_RST 32'h00000000
`define PPS_CFG_RST 32'h000000c8
`define PPS_NOM_RST 32'h00002710
`define PPS_LN_ON 3'h1
`define PPS_LN_BLK 3'h2
`define PPS_LN_TBLK 3'h4
`define PPS_LN_OFF 3'h5
`endif

// ### hw/pps_pkg.sv
package pps_pkg;
   typedef logic signed [31:0] pps_pow_t;
   typedef enum logic [1:0] {ST_IDLE, ST_START, ST_TRIP, ST_BLOCKED} pps_st_t;
   typedef enum logic [1:0] {EV_IDLE, EV_LOG, EV_SEND} pps_ev_t;
endpackage

// ### hw/pps_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pps_mem_if;
   logic we;
   logic [8:0] waddr;
   logic [31:0] wdata;
   logic [8:0] raddr;
   logic [31:0] rdata;
   modport ctl(output we, output waddr, output wdata, output raddr,
      input rdata);
   modport mem(input we, input waddr, input wdata, input raddr,
      output rdata);
endinterface
`default_nettype wire

// ### hw/pps_log_mem.sv
`timescale 1ns/1ps
`default_nettype none
module pps_log_mem #(
   parameter int DEPTH = 512
) (
   input wire logic pclk,
   pps_mem_if.mem m
);
   logic [31:0] ram [DEPTH];
   always_ff @(posedge pclk) begin
      if (m.we) begin
         ram[m.waddr] <= m.wdata;
      end
      m.rdata <= ram[m.raddr];
   end
endmodule
`default_nettype wire

// ### hw/pps_top.sv
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pps_params.svh"
// Summary of operation
// - Blocking input is sampled at each processing tick before pick-up.
// - Pick-up without blocking raises START and starts the operate delay.
// - Pick-up with blocking raises BLOCKED only, no timing, START or TRIP.
// - Blocking after START drops START at the next tick and moves to BLOCKED.
// - Blocking logs an event carrying the values captured at start.
// - With forcing enabled a software switch drives the blocking input.
// - Operate timing is definite-time only; release is immediate.
// - START, TRIP, BLOCKED edges give ON/OFF events, filtered per stage.
// - Four independent stages, each with its own event set.
// - Each stage keeps a 12-entry circular log of ON events.
// - Log entry: stamp, event, -20ms, fault, -200ms power, remaining, SG.
// - Condition reads 0 normal, 1 started, 2 tripped, 3 blocked.
// - Behaviour reads 1 on, 2 blocked, 3 test, 4 test-blocked, 5 off.
// - Measured/pick-up and measured/nominal ratios in 0.01 per unit.
// - Expected time and time left to trip in 5 ms steps.
// - Pick-up in kVA follows the active setting group at once.
// - The nominal power in use is readable whatever its source.
// - Over resets below 97 %, under resets above 103 % of pick-up.
// - Magnitude selects P, Q or S; mode selects over or under.
// - Eight setting groups chosen by one common selector.
// - Instant mode gives START and TRIP with one 1 ms time stamp.
module pps_top import pps_pkg::*; #(
   parameter int MS_CYCLES = `PPS_MS_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [12:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic signed [31:0] p_kw,
   input wire logic signed [31:0] q_kw,
   input wire logic signed [31:0] s_kw,
   input wire logic [31:0] gen_nom_kw,
   input wire logic [31:0] trafo_nom_kw,
   input wire logic [3:0] block_in,
   output logic [3:0] start,
   output logic [3:0] trip,
   output logic [3:0] blocked,
   output logic ev_valid,
   input wire logic ev_ready,
   output logic [1:0] ev_stage,
   output logic [1:0] ev_kind,
   output logic ev_on,
   output logic [31:0] ev_time
);
   function automatic pps_pow_t pick_kw(pps_pow_t pct, logic [31:0] nom);
      logic signed [63:0] t;
      t = 64'(pct) * $signed({32'h0, nom}) / `PPS_PCT_SCALE;
      return t[31:0];
   endfunction

   function automatic logic [31:0] ratio(pps_pow_t num, pps_pow_t den);
      logic signed [63:0] t;
      t = 64'sd0;
      if (den != 32'sh0) begin
         t = 64'(num) * `PPS_RATIO_SCALE / 64'(den);
      end
      return t[31:0];
   endfunction

   function automatic logic [4:0] first_one(logic [31:0] v);
      logic [4:0] r;
      r = 5'h0;
      for (int i = 31; i >= 0; i--) begin
         if (v[i]) begin
            r = 5'(i);
         end
      end
      return r;
   endfunction

   pps_mem_if mif();
   pps_log_mem u_mem (.pclk(pclk), .m(mif.mem));

   logic [31:0] ctrl, next_ctrl, nom_man, next_nom_man;
   logic [31:0] cfg [4], next_cfg [4];
   pps_pow_t gpick [4][8], next_gpick [4][8];
   logic [31:0] gdly [4][8], next_gdly [4][8];
   logic [31:0] time_ms, next_time_ms, ms_cnt, next_ms_cnt;
   logic [2:0] proc_cnt, next_proc_cnt;
   logic [5:0] long_cnt, next_long_cnt;
   logic tick, next_tick, long_tick, next_long_tick;
   logic [2:0] sg;
   logic [31:0] nom_used;
   pps_pow_t meas [4], pk [4];
   logic [31:0] dly [4];

   assign sg = ctrl[`PPS_CTRL_SG_LSB +: 3];
   // Pick-up follows the selector without waiting for a tick.
   always_comb begin
      if (ctrl[`PPS_CTRL_NSRC_LSB +: 2] == 2'h1) begin
         nom_used = gen_nom_kw;
      end else if (ctrl[`PPS_CTRL_NSRC_LSB +: 2] == 2'h2) begin
         nom_used = trafo_nom_kw;
      end else begin
         nom_used = nom_man;
      end
      for (int i = 0; i < 4; i++) begin
         case (cfg[i][`PPS_CFG_MAG_LSB +: 2])
            2'h1: meas[i] = q_kw;
            2'h2: meas[i] = s_kw;
            default: meas[i] = p_kw;
         endcase
         pk[i] = pick_kw(gpick[i][sg], nom_used);
         dly[i] = gdly[i][sg];
      end
   end

   // Time base: 1 ms stamp and a 5 ms processing tick.
   always_comb begin
      next_ms_cnt = ms_cnt + 32'h1;
      next_time_ms = time_ms;
      next_proc_cnt = proc_cnt;
      next_long_cnt = long_cnt;
      next_tick = 1'b0;
      next_long_tick = 1'b0;
      if (ms_cnt == 32'(MS_CYCLES - 1)) begin
         next_ms_cnt = 32'h0;
         next_time_ms = time_ms + 32'h1;
         next_proc_cnt = proc_cnt + 3'h1;
         if (proc_cnt == 3'(`PPS_PROC_MS - 1)) begin
            next_proc_cnt = 3'h0;
            next_tick = 1'b1;
            next_long_cnt = long_cnt + 6'h1;
            if (long_cnt == 6'(`PPS_LONG_TICKS - 1)) begin
               next_long_cnt = 6'h0;
               next_long_tick = 1'b1;
            end
         end
      end
      if (psel && penable && pready && pwrite && paddr[12:4] == 9'h0 &&
            paddr[3:2] == `PPS_OFF_TIME) begin
         next_time_ms = pwdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ms_cnt <= 32'h0;
         time_ms <= 32'h0;
         proc_cnt <= 3'h0;
         long_cnt <= 6'h0;
         tick <= 1'b0;
         long_tick <= 1'b0;
      end else begin
         ms_cnt <= next_ms_cnt;
         time_ms <= next_time_ms;
         proc_cnt <= next_proc_cnt;
         long_cnt <= next_long_cnt;
         tick <= next_tick;
         long_tick <= next_long_tick;
      end
   end

   pps_st_t st [4], next_st [4];
   logic pu [4], next_pu [4];
   logic [31:0] rem [4], next_rem [4];
   pps_pow_t h20 [4][4], next_h20 [4][4];
   pps_pow_t h200a [4], next_h200a [4], h200 [4], next_h200 [4];
   pps_pow_t snf [4], next_snf [4], sn20 [4], next_sn20 [4];
   pps_pow_t sn200 [4], next_sn200 [4];
   logic [3:0] next_start, next_trip, next_blocked;
   logic [31:0] ev_set;
   logic [31:0] stamp, next_stamp;

   // Stage evaluation, one pass per processing tick for all four.
   always_comb begin
      logic blk;
      logic hit;
      logic [2:0] lnm;
      logic [2:0] o;
      logic [2:0] n;
      blk = 1'b0;
      hit = 1'b0;
      lnm = 3'h0;
      o = 3'h0;
      n = 3'h0;
      ev_set = 32'h0;
      next_stamp = tick ? time_ms : stamp;
      for (int i = 0; i < 4; i++) begin
         next_st[i] = st[i];
         next_pu[i] = pu[i];
         next_rem[i] = rem[i];
         next_h200a[i] = h200a[i];
         next_h200[i] = h200[i];
         next_snf[i] = snf[i];
         next_sn20[i] = sn20[i];
         next_sn200[i] = sn200[i];
         for (int k = 0; k < 4; k++) begin
            next_h20[i][k] = h20[i][k];
         end
         if (tick) begin
            lnm = cfg[i][`PPS_CFG_LN_LSB +: 3];
            blk = ctrl[`PPS_CTRL_FORCE] ? cfg[i][`PPS_CFG_FSW] :
               block_in[i];
            blk = blk || lnm == `PPS_LN_BLK || lnm == `PPS_LN_TBLK;
            if (!cfg[i][`PPS_CFG_UNDER]) begin
               hit = meas[i] >= pk[i] || (pu[i] && 64'(meas[i]) * 64'sd100
                  >= 64'(pk[i]) * 64'sd`PPS_OVER_RESET_PCT);
            end else begin
               hit = meas[i] <= pk[i] || (pu[i] && 64'(meas[i]) * 64'sd100
                  <= 64'(pk[i]) * 64'sd`PPS_UNDER_RESET_PCT);
            end
            next_pu[i] = hit && lnm != `PPS_LN_OFF;
            next_h20[i][0] = meas[i];
            for (int k = 1; k < 4; k++) begin
               next_h20[i][k] = h20[i][k-1];
            end
            if (long_tick) begin
               next_h200a[i] = meas[i];
               next_h200[i] = h200a[i];
            end
            // Values at pick-up are kept for start and block logs.
            if (next_pu[i] && !pu[i]) begin
               next_snf[i] = meas[i];
               next_sn20[i] = h20[i][`PPS_SHORT_TICKS - 1];
               next_sn200[i] = h200[i];
            end
            // Release is immediate, so blocking drops START the same way.
            if (!next_pu[i]) begin
               next_st[i] = ST_IDLE;
            end else if (blk) begin
               next_st[i] = ST_BLOCKED;
            end else if (st[i] == ST_START) begin
               if (rem[i] <= 32'h1) begin
                  next_st[i] = ST_TRIP;
                  next_rem[i] = 32'h0;
               end else begin
                  next_rem[i] = rem[i] - 32'h1;
               end
            end else if (st[i] != ST_TRIP) begin
               next_rem[i] = dly[i];
               next_st[i] = dly[i] == 32'h0 ? ST_TRIP : ST_START;
            end
         end
         next_start[i] = next_st[i] == ST_START || next_st[i] == ST_TRIP;
         next_trip[i] = next_st[i] == ST_TRIP;
         next_blocked[i] = next_st[i] == ST_BLOCKED;
         o = {blocked[i], trip[i], start[i]};
         n = {next_blocked[i], next_trip[i], next_start[i]};
         for (int k = 0; k < 3; k++) begin
            if (o[k] != n[k]) begin
               ev_set[i*8 + k*2 + (n[k] ? 0 : 1)] = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '{default: ST_IDLE};
         pu <= '{default: 1'b0};
         rem <= '{default: 32'h0};
         h20 <= '{default: '{default: 32'sh0}};
         h200a <= '{default: 32'sh0};
         h200 <= '{default: 32'sh0};
         snf <= '{default: 32'sh0};
         sn20 <= '{default: 32'sh0};
         sn200 <= '{default: 32'sh0};
         start <= 4'h0;
         trip <= 4'h0;
         blocked <= 4'h0;
         stamp <= 32'h0;
      end else begin
         st <= next_st;
         pu <= next_pu;
         rem <= next_rem;
         h20 <= next_h20;
         h200a <= next_h200a;
         h200 <= next_h200;
         snf <= next_snf;
         sn20 <= next_sn20;
         sn200 <= next_sn200;
         start <= next_start;
         trip <= next_trip;
         blocked <= next_blocked;
         stamp <= next_stamp;
      end
   end

   pps_ev_t evs, next_evs;
   logic [31:0] pend, next_pend, clr;
   logic [4:0] cur, next_cur;
   logic [2:0] wcnt, next_wcnt;
   logic [3:0] logwp [4], next_logwp [4], logcnt [4], next_logcnt [4];
   logic next_ev_valid, next_ev_on;
   logic [1:0] next_ev_stage, next_ev_kind;
   logic [31:0] next_ev_time;

   // Events drain one at a time, lowest pending bit first; only ON events are logged.
   always_comb begin
      logic [1:0] s;
      logic [1:0] k;
      logic en;
      s = cur[4:3];
      k = cur[2:1];
      en = cfg[s][cur[0] ? `PPS_CFG_EVOFF : `PPS_CFG_EVON];
      next_evs = evs;
      next_cur = cur;
      next_wcnt = wcnt;
      next_logwp = logwp;
      next_logcnt = logcnt;
      next_ev_valid = ev_valid;
      next_ev_stage = ev_stage;
      next_ev_kind = ev_kind;
      next_ev_on = ev_on;
      next_ev_time = ev_time;
      clr = 32'h0;
      mif.we = 1'b0;
      mif.waddr = {s, logwp[s], wcnt};
      mif.wdata = 32'h0;
      case (evs)
         EV_IDLE: begin
            if (pend != 32'h0) begin
               next_cur = first_one(pend);
               next_wcnt = 3'h0;
               next_evs = EV_LOG;
            end
         end
         EV_LOG: begin
            if (cur[0]) begin
               next_wcnt = 3'(`PPS_LOG_WORDS - 1);
            end else begin
               mif.we = 1'b1;
               case (wcnt)
                  3'h0: mif.wdata = stamp;
                  3'h1: mif.wdata = {21'h0, sg, 4'h0, s, k};
                  3'h2: mif.wdata = k == 2'h1 ? h20[s][`PPS_SHORT_TICKS - 1]
                     : sn20[s];
                  3'h3: mif.wdata = k == 2'h1 ? meas[s] : snf[s];
                  3'h4: mif.wdata = sn200[s];
                  default: mif.wdata = 32'(rem[s] * `PPS_PROC_MS);
               endcase
               next_wcnt = wcnt + 3'h1;
            end
            if (wcnt == 3'(`PPS_LOG_WORDS - 1)) begin
               if (!cur[0]) begin
                  next_logwp[s] = logwp[s] == 4'(`PPS_LOG_DEPTH - 1) ? 4'h0
                     : logwp[s] + 4'h1;
                  if (logcnt[s] != 4'(`PPS_LOG_DEPTH)) begin
                     next_logcnt[s] = logcnt[s] + 4'h1;
                  end
               end
               if (en) begin
                  next_evs = EV_SEND;
                  next_ev_valid = 1'b1;
                  next_ev_stage = s;
                  next_ev_kind = k;
                  next_ev_on = !cur[0];
                  next_ev_time = stamp;
               end else begin
                  clr[cur] = 1'b1;
                  next_evs = EV_IDLE;
               end
            end
         end
         EV_SEND: begin
            if (ev_ready) begin
               next_ev_valid = 1'b0;
               clr[cur] = 1'b1;
               next_evs = EV_IDLE;
            end
         end
         default: next_evs = EV_IDLE;
      endcase
      next_pend = (pend & ~clr) | ev_set;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evs <= EV_IDLE;
         pend <= 32'h0;
         cur <= 5'h0;
         wcnt <= 3'h0;
         logwp <= '{default: 4'h0};
         logcnt <= '{default: 4'h0};
         ev_valid <= 1'b0;
         ev_stage <= 2'h0;
         ev_kind <= 2'h0;
         ev_on <= 1'b0;
         ev_time <= 32'h0;
      end else begin
         evs <= next_evs;
         pend <= next_pend;
         cur <= next_cur;
         wcnt <= next_wcnt;
         logwp <= next_logwp;
         logcnt <= next_logcnt;
         ev_valid <= next_ev_valid;
         ev_stage <= next_ev_stage;
         ev_kind <= next_ev_kind;
         ev_on <= next_ev_on;
         ev_time <= next_ev_time;
      end
   end

   logic [31:0] rd, next_prdata;
   logic ok, wr, next_pready, next_pslverr;

   // The log read is a registered memory, so every access waits one cycle.
   always_comb begin
      logic [1:0] s;
      logic [2:0] r;
      s = paddr[6:5];
      r = paddr[4:2];
      rd = 32'h0;
      ok = 1'b0;
      mif.raddr = {paddr[10:9], paddr[8:5], paddr[4:2]};
      if (paddr[12]) begin
         ok = !pwrite && paddr[8:5] < 4'(`PPS_LOG_DEPTH) &&
            paddr[4:2] < 3'(`PPS_LOG_WORDS);
         rd = mif.rdata;
      end else if (paddr[11:4] == 8'h0) begin
         ok = !pwrite || paddr[3:2] != `PPS_OFF_NOM_USED;
         if (paddr[3:2] == `PPS_OFF_CTRL) begin
            rd = ctrl;
         end else if (paddr[3:2] == `PPS_OFF_NOM_MAN) begin
            rd = nom_man;
         end else if (paddr[3:2] == `PPS_OFF_TIME) begin
            rd = time_ms;
         end else begin
            rd = nom_used;
         end
      end else if (paddr[11:8] == `PPS_PAGE_STAGE && paddr[7] == 1'b0) begin
         ok = !pwrite || r == 3'h0;
         if (r == 3'h0) begin
            rd = cfg[s];
         end else if (r == 3'h1) begin
            rd = {20'h0, logcnt[s], 2'h0, cfg[s][`PPS_CFG_LN_LSB +: 3], 1'b0,
               2'(st[s])};
         end else if (r == 3'h2) begin
            rd = pk[s];
         end else if (r == 3'h3) begin
            rd = meas[s];
         end else if (r == 3'h4) begin
            rd = ratio(meas[s], pk[s]);
         end else if (r == 3'h5) begin
            rd = ratio(meas[s], $signed(nom_used));
         end else if (r == 3'h6) begin
            rd = 32'(dly[s] * `PPS_PROC_MS);
         end else begin
            rd = st[s] == ST_START ? 32'(rem[s] * `PPS_PROC_MS) : 32'h0;
         end
      end else if (paddr[11:8] == `PPS_PAGE_GROUP) begin
         ok = 1'b1;
         rd = paddr[2] ? gdly[paddr[7:6]][paddr[5:3]] :
            gpick[paddr[7:6]][paddr[5:3]];
      end
      wr = psel && penable && pready && pwrite && ok;
      next_pready = psel && penable && !pready;
      next_prdata = (next_pready && !pwrite && ok) ? rd : 32'h0;
      next_pslverr = next_pready && !ok;
      next_ctrl = ctrl;
      next_nom_man = nom_man;
      next_cfg = cfg;
      next_gpick = gpick;
      next_gdly = gdly;
      if (wr && paddr[12:4] == 9'h0 && paddr[3:2] == `PPS_OFF_CTRL) begin
         next_ctrl = {24'h0, 2'h0, pwdata[5:0]};
      end else if (wr && paddr[12:4] == 9'h0 &&
            paddr[3:2] == `PPS_OFF_NOM_MAN) begin
         next_nom_man = pwdata;
      end else if (wr && paddr[11:8] == `PPS_PAGE_STAGE) begin
         next_cfg[s] = {23'h0, pwdata[8:0]};
      end else if (wr && paddr[11:8] == `PPS_PAGE_GROUP && paddr[2]) begin
         next_gdly[paddr[7:6]][paddr[5:3]] = pwdata;
      end else if (wr && paddr[11:8] == `PPS_PAGE_GROUP) begin
         next_gpick[paddr[7:6]][paddr[5:3]] = pwdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         ctrl <= `PPS_CTRL_RST;
         nom_man <= `PPS_NOM_RST;
         cfg <= '{default: `PPS_CFG_RST};
         gpick <= '{default: '{default: 32'sh0}};
         gdly <= '{default: '{default: 32'h0}};
      end else begin
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         ctrl <= next_ctrl;
         nom_man <= next_nom_man;
         cfg <= next_cfg;
         gpick <= next_gpick;
         gdly <= next_gdly;
      end
   end
endmodule
`default_nettype wire

// ### testbench/pps_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pps_top_monitor #(
   parameter int MS_CYCLES = 40000
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [3:0] start,
   input wire logic [3:0] trip,
   input wire logic [3:0] blocked,
   input wire logic ev_valid,
   input wire logic ev_ready,
   input wire logic [1:0] ev_stage,
   input wire logic [1:0] ev_kind,
   input wire logic ev_on,
   input wire logic [31:0] ev_time
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Ticks are 5 ms apart, so outputs cannot move twice within 8 clocks.
   property p_tick;
      $changed({start, trip, blocked}) |=> $stable({start, trip, blocked})[*8];
   endproperty
   a_tick: assert property (p_tick) else $error("moved between ticks");
   property p_excl;
      (blocked & (start | trip)) == 4'h0;
   endproperty
   a_excl: assert property (p_excl) else $error("blocked with start");
   property p_trip;
      $rose(trip[0]) |-> start[0] || $past(start[0]);
   endproperty
   a_trip: assert property (p_trip) else $error("trip without start");
   property p_hold;
      ev_valid && !ev_ready |=>
         ev_valid && $stable({ev_stage, ev_kind, ev_on, ev_time});
   endproperty
   a_hold: assert property (p_hold) else $error("event not held");
   property p_gap;
      ev_valid && ev_ready |=> !ev_valid;
   endproperty
   a_gap: assert property (p_gap) else $error("event not dropped");
   property p_kind;
      ev_valid |-> ev_kind != 2'h3;
   endproperty
   a_kind: assert property (p_kind) else $error("bad event kind");
   property p_answer;
      psel && !penable |-> ##2 pready;
   endproperty
   a_answer: assert property (p_answer) else $error("pready late");
   property p_pulse;
      pready |=> !pready;
   endproperty
   a_pulse: assert property (p_pulse) else $error("pready too long");
   property p_err;
      pslverr |-> pready && prdata == 32'h0;
   endproperty
   a_err: assert property (p_err) else $error("bad error answer");
   property p_idle;
      !pready |-> prdata == 32'h0;
   endproperty
   a_idle: assert property (p_idle) else $error("prdata not zero");
endmodule
bind pps_top pps_top_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (.pclk, .presetn,
   .psel, .penable, .prdata, .pready, .pslverr, .start, .trip, .blocked,
   .ev_valid, .ev_ready, .ev_stage, .ev_kind, .ev_on, .ev_time);
`default_nettype wire

// ### testbench/pps_ev_sink.sv
`timescale 1ns/1ps
`default_nettype none
module pps_ev_sink (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ev_valid,
   input wire logic [1:0] ev_kind,
   input wire logic ev_on,
   input wire logic slow,
   output logic ev_ready,
   output int n_ev,
   output logic [3:0] seen
);
   logic ph;
   // In slow mode the buffer accepts only every other cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ph <= 1'b0;
         ev_ready <= 1'b0;
         n_ev <= 0;
         seen <= 4'h0;
      end else begin
         ph <= ~ph;
         ev_ready <= !slow || ph;
         if (ev_valid && ev_ready) begin
            n_ev <= n_ev + 1;
            if (ev_on) begin
               seen[ev_kind] <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### testbench/power_protection_stage_logic_test.sv
`timescale 1ns/1ps
`default_nettype none
module power_protection_stage_logic_test;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, slow = 1'b0, pready, pslverr, er;
   logic [12:0] paddr = 13'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd, ev_time, nom = 32'h4e20;
   // Idle power is -1 kW, so a zero pick-up cannot start a stage early.
   logic signed [31:0] p_kw = 32'hffffffff, q_kw = 32'h0, s_kw = 32'h0;
   logic [3:0] block_in = 4'h0, start, trip, blocked, seen;
   logic [1:0] ev_stage, ev_kind;
   logic ev_valid, ev_ready, ev_on;
   logic [2:0] o;
   int fail_count = 0, n_checks = 0, n_ev, k;
   assign o = {blocked[0], trip[0], start[0]};
   always #12.5 pclk = ~pclk;
   pps_top #(.MS_CYCLES(4)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .p_kw, .q_kw, .s_kw,
      .gen_nom_kw(nom), .trafo_nom_kw(nom), .block_in, .start, .trip,
      .blocked, .ev_valid, .ev_ready, .ev_stage, .ev_kind, .ev_on, .ev_time);
   pps_ev_sink u_sink (.pclk, .presetn, .ev_valid, .ev_kind, .ev_on, .slow,
      .ev_ready, .n_ev, .seen);
   task report_and_stop;
      if (fail_count == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask
   task hang(input string nm);
      $display("ERROR %s expected done seen timeout", nm);
      fail_count++;
      report_and_stop;
   endtask
   task apb(input logic w, input logic [12:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) hang("apb");
   endtask
   task rdc(input string nm, input logic [12:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask
   // Counts clocks until the watched output reaches the wanted level.
   task wt(input int i, input logic v);
      k = 0;
      while (o[i] !== v && k < 300) begin
         @(posedge pclk);
         k++;
      end
      if (k >= 300) hang("wait");
   endtask
   task pick(input logic [31:0] p, input logic [3:0] b);
      @(posedge pclk);
      p_kw <= p;
      block_in <= b;
   endtask
   task t_regs;
      rdc("ctrl", 13'h0, 32'h0);
      rdc("nom_man", 13'h4, 32'h2710);
      rdc("nom_used", 13'hc, 32'h2710);
      rdc("cfg", 13'h100, 32'hc8);
      rdc("unmapped_rd", 13'h180, 32'h0);
      chk("unmapped", 32'h1, er);
      apb(1'b1, 13'hc, 32'h5);
      chk("ro_write", 32'h1, er);
      apb(1'b1, 13'h120, 32'he8);
      apb(1'b1, 13'h140, 32'he8);
      apb(1'b1, 13'h160, 32'he8);
      rdc("stat_off", 13'h164, 32'h28);
      apb(1'b1, 13'h200, 32'h7d0);
      apb(1'b1, 13'h204, 32'h3);
      rdc("pickup", 13'h108, 32'h3e8);
      apb(1'b1, 13'h0, 32'h11);
      rdc("nom_gen", 13'hc, 32'h4e20);
      rdc("pickup_sg1", 13'h108, 32'h0);
      apb(1'b1, 13'h0, 32'h0);
   endtask
   task t_trip;
      pick(32'h1388, 4'h0);
      wt(0, 1'b1);
      wt(1, 1'b1);
      chk("trip_delay", 32'd60, k);
      repeat (20) @(posedge pclk);
      rdc("stat_trip", 13'h104, 32'h20a);
      rdc("log_kind", 13'h1024, 32'h1);
      rdc("ratio", 13'h110, 32'h1f4);
      rdc("exp_time", 13'h118, 32'hf);
      pick(32'h3d4, 4'h0);
      repeat (25) @(posedge pclk);
      chk("hyst", 32'h1, trip[0]);
      pick(32'h0, 4'h0);
      wt(0, 1'b0);
      chk("trip_clr", 32'h0, trip[0]);
      repeat (40) @(posedge pclk);
      chk("events", 32'd4, n_ev);
      chk("seen", 32'h3, seen);
   endtask
   task t_block;
      slow <= 1'b1;
      pick(32'h1388, 4'h1);
      wt(2, 1'b1);
      chk("blk_start", 32'h0, start[0]);
      repeat (12) @(posedge pclk);
      rdc("stat_blk", 13'h104, 32'h30b);
      pick(32'h0, 4'h0);
      wt(2, 1'b0);
      pick(32'h1388, 4'h0);
      wt(0, 1'b1);
      pick(32'h1388, 4'h1);
      wt(2, 1'b1);
      chk("late_blk", 32'h0, start[0]);
      pick(32'h0, 4'h0);
      wt(2, 1'b0);
      repeat (60) @(posedge pclk);
      chk("ev_slow", 32'd10, n_ev);
   endtask
   task t_force;
      apb(1'b1, 13'h0, 32'h8);
      apb(1'b1, 13'h100, 32'h1c8);
      pick(32'h1388, 4'h0);
      wt(2, 1'b1);
      chk("force_blk", 32'h0, start[0]);
      pick(32'h0, 4'h0);
      apb(1'b1, 13'h100, 32'hc8);
      wt(2, 1'b0);
   endtask
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_trip;
      t_block;
      t_force;
      report_and_stop;
   end
endmodule
`default_nettype wire
